// *** src/rrs_pkg.sv ***
// shared constants for the rotate/fill/halt execution block
package rrs_pkg;
  // ***************************************************************
  // instruction encodings
  // ***************************************************************
  localparam logic [5:0] OPC_ROTATE = 6'h10;
  localparam logic [6:0] OPC_FILL = 7'h34;
  localparam logic [15:0] OPC_HALT = 16'h0003;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] INDEXED_MAX = 8'h5F;
  localparam logic [7:0] WDOG_CLEARED = 8'h00;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  // ***************************************************************
  // register map, byte addresses
  // ***************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BANK = 8'h04;
  localparam logic [7:0] OFF_ACCUM = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_INDEX = 8'h10;
  localparam logic [7:0] OFF_WIN_ADDR = 8'h14;
  localparam logic [7:0] OFF_WIN_DATA = 8'h18;
  localparam logic [7:0] OFF_WDOG = 8'h1C;
  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_WDOG_BIT = 1;
  localparam int ST_C_BIT = 0;
  localparam int ST_Z_BIT = 1;
  localparam int ST_N_BIT = 2;
  localparam int ST_POWERDOWN_BIT = 3;
  localparam int ST_EXPIRY_BIT = 4;
  localparam int ST_HALT_BIT = 5;
  localparam logic RST_POWERDOWN = 1'b1;
  localparam logic RST_EXPIRY = 1'b1;
  localparam logic RST_WDOG_EN = 1'b1;
  // ***************************************************************
  // phases of one instruction cycle
  // ***************************************************************
  typedef enum logic [2:0] {
    PH_DECODE = 3'b000,
    PH_READ = 3'b001,
    PH_PROC = 3'b010,
    PH_WRITE = 3'b011,
    PH_HALT = 3'b100
  } rrs_phase_t;
endpackage : rrs_pkg

// *** src/rrs_regfile.sv ***
// byte-wide file register memory, one read and one write port
`timescale 1ns/100ps
module rrs_regfile #(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [ADDR_W-1:0] raddr,
  output logic [7:0] rdata
);
  // no reset: contents are undefined at power-up, as in any sram
  logic [7:0] mem [2**ADDR_W];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule : rrs_regfile

// *** src/rrs_wdog.sv ***
// watchdog counter with postscaler
`timescale 1ns/100ps
module rrs_wdog import rrs_pkg::*; #(
  parameter int POST_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic clear,
  output logic [7:0] count,
  output logic expiry
);
  typedef struct packed {
    logic [POST_W-1:0] post;
    logic [7:0] cnt;
    logic exp;
  } rrs_wdog_state_t;

  rrs_wdog_state_t s_reg;
  rrs_wdog_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.exp = 1'b0;
    if (clear) begin
      s_next.post = '0;
      s_next.cnt = WDOG_CLEARED;
    end else if (enable) begin
      s_next.post = POST_W'(s_reg.post + 1'b1);
      if (&s_reg.post) begin
        s_next.cnt = s_reg.cnt + 8'h01;
        s_next.exp = &s_reg.cnt;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign count = s_reg.cnt;
  assign expiry = s_reg.exp;

  wdog_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    clear |=> (count == WDOG_CLEARED) && !expiry ##1 !expiry)
    else $error("watchdog not cleared");
endmodule : rrs_wdog

// *** src/rrs_core.sv ***
// execution unit for rotate-right, fill-ones and halt, with apb registers
//
// Operation
// - rotate right without carry: bit 0 into bit 7, updates N and Z only
// - rotate destination bit: 0 to accumulator, 1 back to file register
// - bank bit 0 selects access bank, 1 uses bank select register
// - extended set, bank bit 0, address up to 5Fh: indexed literal offset
// - fill with bank bit 1 uses bank select register, 0 the access bank
// - rotate decoded from 0100 00da plus address, one instruction cycle
// - halt instruction, word 0003h, clears the power-down flag
// - halt instruction sets the expiry flag
// - halt instruction clears watchdog count and its postscaler
// - after halt the core stops with its oscillator off
// - watchdog wake-up from halt clears the expiry flag
`timescale 1ns/100ps
module rrs_core import rrs_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int WDOG_POST_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  input wire logic wake_event,
  output logic osc_run
);
  localparam int BANK_W = ADDR_W - 8;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    rrs_phase_t ph;
    logic [15:0] ir;
    logic [7:0] opnd;
    logic [7:0] res;
    logic [ADDR_W-1:0] addr;
    logic [7:0] w;
    logic n;
    logic z;
    logic c;
    logic powerdown_flag;
    logic expiry_flag;
    logic [BANK_W-1:0] bank_select_register;
    logic ext_en;
    logic wdog_en;
    logic [ADDR_W-1:0] idx_base;
    logic [ADDR_W-1:0] win_addr;
    logic [31:0] prdata;
    logic was_busy;
  } rrs_core_state_t;

  rrs_core_state_t s_reg;
  rrs_core_state_t s_next;

  // ***************************************************************
  // decoding helpers
  // ***************************************************************
  function automatic logic is_rotate(input logic [15:0] iw);
    return iw[15:10] == OPC_ROTATE;
  endfunction : is_rotate

  function automatic logic is_fill(input logic [15:0] iw);
    return iw[15:9] == OPC_FILL;
  endfunction : is_fill

  function automatic logic is_halt(input logic [15:0] iw);
    return iw == OPC_HALT;
  endfunction : is_halt

  // bank bit 1 takes the bank register; bank bit 0 splits the access bank
  function automatic logic [ADDR_W-1:0] eff_addr(
    input logic [15:0] iw,
    input logic [BANK_W-1:0] bank,
    input logic ext,
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W-1:0] r;
    r = '0;
    if (iw[BANK_BIT]) begin
      r = {bank, iw[7:0]};
    end else if (ext && iw[7:0] <= INDEXED_MAX) begin
      r = ADDR_W'(base + {{BANK_W{1'b0}}, iw[7:0]});
    end else if (iw[7:0] <= INDEXED_MAX) begin
      r = {{BANK_W{1'b0}}, iw[7:0]};
    end else begin
      r = {{BANK_W{1'b1}}, iw[7:0]};
    end
    return r;
  endfunction : eff_addr

  // ***************************************************************
  // file registers and watchdog
  // ***************************************************************
  logic mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [ADDR_W-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic core_we;
  logic wd_clear;
  logic [7:0] wd_count;
  logic wd_expiry;
  logic busy;
  logic acc;
  logic win_sel;
  logic apb_wr;
  logic mapped;
  logic [31:0] rd_mux;

  rrs_regfile #(.ADDR_W(ADDR_W)) u_regfile (
    .sys_clk(sys_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  rrs_wdog #(.POST_W(WDOG_POST_W)) u_wdog (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .enable(s_reg.wdog_en),
    .clear(wd_clear),
    .count(wd_count),
    .expiry(wd_expiry)
  );

  // ***************************************************************
  // bus slave
  // ***************************************************************
  // window stalls while an instruction owns the ports, one cycle more so prdata is refetched
  assign busy = s_reg.ph inside {PH_READ, PH_PROC, PH_WRITE};
  assign acc = psel && penable;
  assign win_sel = paddr == OFF_WIN_DATA;
  assign pready = acc && !(win_sel && (busy || s_reg.was_busy));
  assign apb_wr = pready && pwrite;
  assign pslverr = pready && !mapped;
  assign prdata = s_reg.prdata;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_CTRL: begin
        rd_mux[CTRL_EXT_BIT] = s_reg.ext_en;
        rd_mux[CTRL_WDOG_BIT] = s_reg.wdog_en;
      end
      OFF_BANK: rd_mux[BANK_W-1:0] = s_reg.bank_select_register;
      OFF_ACCUM: rd_mux[7:0] = s_reg.w;
      OFF_STATUS: begin
        rd_mux[ST_C_BIT] = s_reg.c;
        rd_mux[ST_Z_BIT] = s_reg.z;
        rd_mux[ST_N_BIT] = s_reg.n;
        rd_mux[ST_POWERDOWN_BIT] = s_reg.powerdown_flag;
        rd_mux[ST_EXPIRY_BIT] = s_reg.expiry_flag;
        rd_mux[ST_HALT_BIT] = s_reg.ph == PH_HALT;
      end
      OFF_INDEX: rd_mux[ADDR_W-1:0] = s_reg.idx_base;
      OFF_WIN_ADDR: rd_mux[ADDR_W-1:0] = s_reg.win_addr;
      OFF_WIN_DATA: rd_mux[7:0] = mem_rdata;
      OFF_WDOG: rd_mux[7:0] = wd_count;
      default: mapped = 1'b0;
    endcase
  end

  // ***************************************************************
  // memory ports
  // ***************************************************************
  assign core_we = s_reg.ph == PH_WRITE &&
    ((is_rotate(s_reg.ir) && s_reg.ir[DEST_BIT]) || is_fill(s_reg.ir));
  assign mem_we = core_we || (apb_wr && win_sel);
  assign mem_waddr = core_we ? s_reg.addr : s_reg.win_addr;
  assign mem_wdata = core_we ? s_reg.res : pwdata[7:0];
  assign mem_raddr = busy ? s_reg.addr : s_reg.win_addr;
  assign wd_clear = s_reg.ph == PH_WRITE && is_halt(s_reg.ir);
  assign instr_ready = s_reg.ph == PH_DECODE;
  assign osc_run = s_reg.ph != PH_HALT;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.was_busy = busy;
    if (psel) begin
      s_next.prdata = rd_mux;
    end
    if (apb_wr) begin
      case (paddr)
        OFF_CTRL: begin
          s_next.ext_en = pwdata[CTRL_EXT_BIT];
          s_next.wdog_en = pwdata[CTRL_WDOG_BIT];
        end
        OFF_BANK: s_next.bank_select_register = pwdata[BANK_W-1:0];
        OFF_ACCUM: s_next.w = pwdata[7:0];
        OFF_STATUS: begin
          s_next.c = pwdata[ST_C_BIT];
          s_next.z = pwdata[ST_Z_BIT];
          s_next.n = pwdata[ST_N_BIT];
        end
        OFF_INDEX: s_next.idx_base = pwdata[ADDR_W-1:0];
        OFF_WIN_ADDR: s_next.win_addr = pwdata[ADDR_W-1:0];
        default: s_next.c = s_reg.c;
      endcase
    end
    // a timeout clears expiry; a halt in the same cycle sets it again
    if (wd_expiry) begin
      s_next.expiry_flag = 1'b0;
    end
    case (s_reg.ph)
      PH_DECODE: begin
        if (instr_valid) begin
          s_next.ir = instr_word;
          if (is_rotate(instr_word) || is_fill(instr_word) ||
              is_halt(instr_word)) begin
            s_next.ph = PH_READ;
          end
          s_next.addr = eff_addr(instr_word, s_reg.bank_select_register, s_reg.ext_en,
            s_reg.idx_base);
        end
      end
      PH_READ: begin
        s_next.opnd = mem_rdata;
        s_next.ph = PH_PROC;
      end
      PH_PROC: begin
        if (is_rotate(s_reg.ir)) begin
          s_next.res = {s_reg.opnd[0], s_reg.opnd[7:1]};
        end else begin
          s_next.res = ALL_ONES;
        end
        s_next.ph = PH_WRITE;
      end
      PH_WRITE: begin
        s_next.ph = PH_DECODE;
        if (is_rotate(s_reg.ir)) begin
          s_next.n = s_reg.res[7];
          s_next.z = s_reg.res == 8'h00;
          if (!s_reg.ir[DEST_BIT]) begin
            s_next.w = s_reg.res;
          end
        end
        if (is_halt(s_reg.ir)) begin
          s_next.powerdown_flag = 1'b0;
          s_next.expiry_flag = 1'b1;
          s_next.ph = PH_HALT;
        end
      end
      PH_HALT: begin
        // any wake keeps powerdown clear; only the watchdog clears expiry
        if (wd_expiry || wake_event) begin
          s_next.ph = PH_DECODE;
        end
      end
      default: s_next.ph = PH_DECODE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.ph <= PH_DECODE;
      s_reg.powerdown_flag <= RST_POWERDOWN;
      s_reg.expiry_flag <= RST_EXPIRY;
      s_reg.wdog_en <= RST_WDOG_EN;
    end else begin
      s_reg <= s_next;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic st_wr;
  assign st_wr = apb_wr && paddr == OFF_STATUS;

  rotate_value_a: assert property (
    s_reg.ph == PH_PROC && is_rotate(s_reg.ir) && s_reg.ir[DEST_BIT] |=>
    mem_we && mem_wdata == {$past(s_reg.opnd[0]), $past(s_reg.opnd[7:1])})
    else $error("rotate result wrong");

  rotate_carry_a: assert property (
    s_reg.ph == PH_WRITE && is_rotate(s_reg.ir) && !st_wr |=>
    $stable(s_reg.c) && s_reg.z == ($past(s_reg.res) == 8'h00))
    else $error("rotate flags wrong");

  rotate_accum_a: assert property (
    s_reg.ph == PH_WRITE && is_rotate(s_reg.ir) && !s_reg.ir[DEST_BIT] |->
    !mem_we ##1 s_reg.w == $past(s_reg.res))
    else $error("accumulator destination wrong");

  bank_select_a: assert property (
    instr_ready && instr_valid && instr_word[BANK_BIT] |=>
    s_reg.addr == {$past(s_reg.bank_select_register), s_reg.ir[7:0]})
    else $error("banked address wrong");

  indexed_mode_a: assert property (
    instr_ready && instr_valid && !instr_word[BANK_BIT] && s_reg.ext_en &&
    instr_word[7:0] <= INDEXED_MAX |=>
    s_reg.addr == ADDR_W'($past(s_reg.idx_base) + {{BANK_W{1'b0}}, s_reg.ir[7:0]}))
    else $error("indexed address wrong");

  fill_ones_a: assert property (
    s_reg.ph == PH_WRITE && is_fill(s_reg.ir) && !st_wr |->
    mem_we && mem_wdata == ALL_ONES ##1 $stable({s_reg.n, s_reg.z, s_reg.c}))
    else $error("fill instruction wrong");

  halt_flags_a: assert property (
    s_reg.ph == PH_WRITE && is_halt(s_reg.ir) |=>
    !s_reg.powerdown_flag && s_reg.expiry_flag && !osc_run)
    else $error("halt flags wrong");

  phase_order_a: assert property (
    instr_ready && instr_valid && is_rotate(instr_word) |=>
    s_reg.ph == PH_READ ##1 s_reg.ph == PH_PROC ##1 s_reg.ph == PH_WRITE
    ##1 s_reg.ph == PH_DECODE)
    else $error("phase order wrong");

  wdog_wake_a: assert property (
    s_reg.ph == PH_HALT && wd_expiry |=> !s_reg.expiry_flag && osc_run)
    else $error("watchdog wake wrong");
endmodule : rrs_core

// *** verif/rrs_core_tb_top.sv ***
// testbench for the rotate/fill/halt execution block
`timescale 1ns/100ps
module rrs_core_tb_top import rrs_pkg::*; ;
  // ***************************************************************
  // design hookup
  // ***************************************************************
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic instr_ready;
  logic wake_event = 1'b0;
  logic osc_run;
  logic [31:0] rdat;
  logic rerr;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  // short postscaler keeps the watchdog wake near 512 cycles
  rrs_core #(.ADDR_W(12), .WDOG_POST_W(1)) i_rrs_core (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready),
    .wake_event(wake_event), .osc_run(osc_run)
  );

  always #5 sys_clk = ~sys_clk;

  // ***************************************************************
  // helpers
  // ***************************************************************
  task end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // a hang anywhere lands here
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; idle cycle after so psel never toggles in one step
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask : rdc

  task fput(input logic [11:0] a, input logic [7:0] d);
    wr(OFF_WIN_ADDR, {20'h0, a});
    wr(OFF_WIN_DATA, {24'h0, d});
  endtask : fput

  task fchk(input logic [11:0] a, input logic [7:0] exp);
    wr(OFF_WIN_ADDR, {20'h0, a});
    rdc(OFF_WIN_DATA, {24'h0, exp});
  endtask : fchk

  function automatic logic [31:0] st(input logic c, z, n, pdn, ex, h);
    logic [31:0] v;
    v = 32'h0;
    v[ST_C_BIT] = c;
    v[ST_Z_BIT] = z;
    v[ST_N_BIT] = n;
    v[ST_POWERDOWN_BIT] = pdn;
    v[ST_EXPIRY_BIT] = ex;
    v[ST_HALT_BIT] = h;
    return v;
  endfunction : st

  // offers one word, then counts busy cycles over the four that follow
  task exec(input logic [15:0] w, input int lows);
    int n;
    n = 0;
    instr_valid <= 1'b1;
    instr_word <= w;
    do @(posedge sys_clk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    repeat (4) begin
      @(posedge sys_clk);
      if (instr_ready !== 1'b1) n++;
    end
    check(n, lows);
  endtask : exec

  task wait_osc(input int bound);
    for (int i = 0; i < bound && osc_run !== 1'b1; i++) @(posedge sys_clk);
    check(osc_run, 1'b1);
  endtask : wait_osc

  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rdc(OFF_STATUS, st(0, 0, 0, 1, 1, 0));
    rdc(OFF_CTRL, 32'h2);
    rdc(8'h20, 32'h0);
    check(rerr, 1'b1);
    // watchdog off so the expiry flag holds still until the halt tests
    wr(OFF_CTRL, 32'h0);
    $display("test reset done");
    wr(OFF_BANK, 32'h2);
    wr(OFF_STATUS, 32'h1);
    fput(12'h234, 8'hD7);
    exec(16'h4334, 3);
    fchk(12'h234, 8'hEB);
    rdc(OFF_STATUS, st(1, 0, 1, 1, 1, 0));
    fput(12'h010, 8'hD7);
    wr(OFF_ACCUM, 32'h0);
    exec(16'h4010, 3);
    rdc(OFF_ACCUM, 32'hEB);
    fchk(12'h010, 8'hD7);
    fput(12'hF80, 8'h00);
    exec(16'h4280, 3);
    fchk(12'hF80, 8'h00);
    rdc(OFF_STATUS, st(1, 1, 0, 1, 1, 0));
    fput(12'h034, 8'h01);
    exec(16'h4234, 3);
    fchk(12'h034, 8'h80);
    fchk(12'h234, 8'hEB);
    // window read while the core rewrites the same byte: must stall and see the new value
    fork
      exec(16'h4334, 3);
      begin
        @(posedge sys_clk);
        rdc(OFF_WIN_DATA, 32'hF5);
      end
    join
    $display("test rotate done");
    wr(OFF_BANK, 32'h3);
    fput(12'h305, 8'h5A);
    exec(16'h6905, 3);
    fchk(12'h305, 8'hFF);
    fput(12'hF90, 8'h00);
    exec(16'h6890, 3);
    fchk(12'hF90, 8'hFF);
    rdc(OFF_STATUS, st(1, 0, 1, 1, 1, 0));
    exec(16'hF000, 0);
    $display("test fill done");
    wr(OFF_CTRL, 32'h1);
    wr(OFF_INDEX, 32'h500);
    fput(12'h55F, 8'h00);
    fput(12'h05F, 8'h00);
    exec(16'h685F, 3);
    fchk(12'h55F, 8'hFF);
    fchk(12'h05F, 8'h00);
    fput(12'hF60, 8'h00);
    exec(16'h6860, 3);
    fchk(12'hF60, 8'hFF);
    fput(12'h520, 8'h02);
    exec(16'h4220, 3);
    fchk(12'h520, 8'h01);
    wr(OFF_CTRL, 32'h0);
    $display("test indexed done");
    exec(OPC_HALT, 4);
    check(osc_run, 1'b0);
    rdc(OFF_STATUS, st(1, 0, 0, 0, 1, 1));
    rdc(OFF_WDOG, 32'h0);
    wake_event <= 1'b1;
    @(posedge sys_clk);
    wake_event <= 1'b0;
    wait_osc(8);
    rdc(OFF_STATUS, st(1, 0, 0, 0, 1, 0));
    wr(OFF_CTRL, 32'h2);
    exec(OPC_HALT, 4);
    wait_osc(1500);
    rdc(OFF_STATUS, st(1, 0, 0, 0, 0, 0));
    exec(OPC_HALT, 4);
    rdc(OFF_STATUS, st(1, 0, 0, 0, 1, 1));
    $display("test halt done");
    end_of_test();
  end
endmodule : rrs_core_tb_top
